/* core/isa_exec_inc_to_xor.sv */
// Decode and execute stage for part of a 14-bit instruction set.
// Assumes the program memory presents instr_word for the current pc in the same cycle,
// and that software controls run and wake over AXI4-Lite.
//
// Local design decisions: the address map and the AXI4-Lite slave port.

`timescale 1ns/1ps

module isa_exec_inc_to_xor #(
  parameter int PC_W = isa_exec_pkg::PC_WIDTH,
  parameter int STACK_DEPTH = isa_exec_pkg::STACK_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [13:0] instr_word,
  output logic [PC_W-1:0] pc,
  output logic standby,
  output logic sreg_wr_en,
  output logic [5:0] sreg_addr,
  output logic [7:0] sreg_data,
  input wire logic [isa_exec_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [isa_exec_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int SP_W = $clog2(STACK_DEPTH);

  // ==========================================================================
  // Architectural state.
  // ==========================================================================
  logic [PC_W-1:0] pc_ff; // Address of the word now presented.
  logic [PC_W-1:0] nxt_pc;
  logic [7:0] acc_ff; // Accumulator.
  isa_exec_pkg::status_s status_ff; // Status flags.
  isa_exec_pkg::status_s nxt_status;
  logic gie_ff; // Global interrupt enable.
  isa_exec_pkg::core_state_e state_ff;
  isa_exec_pkg::core_state_e nxt_state;
  logic [7:0] file_mem [isa_exec_pkg::FILE_DEPTH]; // Data file registers.
  logic [PC_W-1:0] stk_mem [STACK_DEPTH]; // Return stack.
  logic [SP_W-1:0] sp_ff; // Next free stack slot.
  logic sreg_wr_en_ff;
  logic [5:0] sreg_addr_ff;
  logic [7:0] sreg_data_ff;
  logic run_ff; // Software run enable.
  logic wake_req; // One-cycle wake pulse from a control write.

  // ==========================================================================
  // Field extraction and decode.
  // ==========================================================================
  wire [5:0] opc = instr_word[13:8];
  wire dest_file = instr_word[7]; // see RL9
  wire [6:0] faddr = instr_word[6:0]; // see RL9
  wire [7:0] lit = instr_word[7:0];
  wire is_nop = (instr_word == isa_exec_pkg::NOP_WORD); // see RL22
  wire is_standby = (instr_word == isa_exec_pkg::STANDBY_WORD);
  wire is_sub_exit = (instr_word == isa_exec_pkg::SUB_EXIT_WORD);
  wire is_irq_exit = (instr_word == isa_exec_pkg::IRQ_EXIT_WORD);
  // Register field 00h..3Fh shares its prefix with a few control words.
  wire is_port_store = (instr_word[13:6] == isa_exec_pkg::PORT_STORE_PFX) && !is_nop && !is_standby
    && (instr_word != isa_exec_pkg::WDT_CLEAR_WORD);
  wire is_file_store = (instr_word[13:7] == isa_exec_pkg::FILE_STORE_PFX);
  wire is_load_file = (opc == isa_exec_pkg::OP_LOAD_ZT) && !instr_word[7];
  wire is_zero_test = (opc == isa_exec_pkg::OP_LOAD_ZT) && instr_word[7];
  wire is_call = (instr_word[13:12] == isa_exec_pkg::CALL_PFX);
  wire is_jump = (instr_word[13:12] == isa_exec_pkg::JUMP_PFX);
  wire is_inc = (opc == isa_exec_pkg::OP_INC);
  wire is_incsz = (opc == isa_exec_pkg::OP_INCSZ);
  wire is_or_f = (opc == isa_exec_pkg::OP_OR_F);
  wire is_xor_f = (opc == isa_exec_pkg::OP_XOR_F);
  wire is_sub = (opc == isa_exec_pkg::OP_SUB);
  wire is_rlf = (opc == isa_exec_pkg::OP_RLF);
  wire is_swap = (opc == isa_exec_pkg::OP_SWAP);
  wire is_or_l = (opc == isa_exec_pkg::OP_OR_LIT);
  wire is_xor_l = (opc == isa_exec_pkg::OP_XOR_LIT); // see RL18
  wire is_load_lit = (opc == isa_exec_pkg::OP_LOAD_LIT);
  wire is_table_exit = (opc == isa_exec_pkg::OP_TABLE_EXIT);

  // Byte operations that honour the destination bit.
  wire is_byte_d = is_inc | is_incsz | is_or_f | is_xor_f | is_sub | is_rlf | is_swap;
  // Operations whose second operand is the literal instead of the file.
  wire is_lit_op = is_or_l | is_xor_l | is_load_lit | is_table_exit;
  wire is_return = is_sub_exit | is_irq_exit | is_table_exit;

  // ==========================================================================
  // Operand fetch and arithmetic.
  // ==========================================================================
  wire [7:0] file_rd = file_mem[faddr];
  wire [7:0] alu_b = is_lit_op ? lit : file_rd;
  wire [7:0] alu_res;
  wire alu_c;
  wire alu_dc;
  wire alu_z;
  isa_exec_pkg::alu_op_e alu_sel;

  assign alu_sel = (is_inc | is_incsz) ? isa_exec_pkg::ALU_INC :
                   (is_or_f | is_or_l) ? isa_exec_pkg::ALU_OR :
                   (is_xor_f | is_xor_l) ? isa_exec_pkg::ALU_XOR :
                   is_sub ? isa_exec_pkg::ALU_SUB :
                   is_rlf ? isa_exec_pkg::ALU_RLF :
                   is_swap ? isa_exec_pkg::ALU_SWAP : isa_exec_pkg::ALU_PASS;

  byte_alu u_alu (
    .op(alu_sel),
    .acc(acc_ff),
    .opnd(alu_b),
    .carry_in(status_ff.carry),
    .result(alu_res),
    .carry_out(alu_c),
    .half_carry_out(alu_dc),
    .zero_out(alu_z)
  );

  // ==========================================================================
  // Write-back selection.
  // ==========================================================================
  // Nothing executes while stopped by software or while a slot is discarded.
  wire exec = (state_ff == isa_exec_pkg::ST_EXEC) && run_ff;
  // Accumulator targets: byte ops with d clear, literal ops and file loads.
  wire acc_we = exec && ((is_byte_d && !dest_file) || is_or_l || is_xor_l // see RL3
    || is_load_lit || is_table_exit || is_load_file); // see RL5
  // File targets: byte ops with d set, and the accumulator store.
  wire file_we = exec && ((is_byte_d && dest_file) || is_file_store); // see RL7
  wire [7:0] file_wd = is_file_store ? acc_ff : alu_res;
  wire z_upd = is_inc | is_or_f | is_or_l | is_xor_f | is_xor_l | is_sub | is_zero_test; // see RL17
  wire c_upd = is_sub | is_rlf; // see RL13
  wire [SP_W-1:0] sp_top = sp_ff - {{(SP_W-1){1'b0}}, 1'b1};
  wire [PC_W-1:0] stack_top_entry = stk_mem[sp_top];
  wire [PC_W-1:0] pc_inc = pc_ff + {{(PC_W-1){1'b0}}, 1'b1};
  wire push = exec && is_call;
  wire pop = exec && is_return;

  // ==========================================================================
  // Flag next values.
  // ==========================================================================
  // Every flag holds unless its instruction lists it, so no-flag ops leave all alone.
  always_comb begin
    nxt_status = status_ff;
    if (exec) begin
      if (z_upd) begin
        nxt_status.zero = alu_z; // see RL21
      end
      if (c_upd) begin
        nxt_status.carry = alu_c; // see RL15
      end
      if (is_sub) begin
        nxt_status.half_carry = alu_dc; // see RL15
      end
      if (is_standby) begin
        nxt_status.wd_expiry = 1'b1; // see RL14
        nxt_status.power_down = 1'b0;
      end
    end
  end

  // ==========================================================================
  // Sequencer: program counter and slot state.
  // ==========================================================================
  // A skip discards the next word and moves on; a jump waits one slot at the target.
  always_comb begin
    nxt_pc = pc_inc;
    nxt_state = isa_exec_pkg::ST_EXEC;
    case (state_ff)
      isa_exec_pkg::ST_EXEC: begin
        if (!run_ff) begin
          nxt_pc = pc_ff;
        end else if (is_standby) begin
          nxt_state = isa_exec_pkg::ST_SLEEP; // see RL14
        end else if (is_return) begin
          nxt_pc = stack_top_entry; // see RL10
          nxt_state = isa_exec_pkg::ST_WAIT; // see RL12
        end else if (is_call || is_jump) begin
          nxt_pc = instr_word[PC_W-1:0];
          nxt_state = isa_exec_pkg::ST_WAIT;
        end else if (is_incsz && alu_z) begin
          nxt_state = isa_exec_pkg::ST_SKIP; // see RL2
        end
      end
      isa_exec_pkg::ST_SKIP: begin
        nxt_pc = pc_inc;
      end
      isa_exec_pkg::ST_WAIT: begin
        nxt_pc = pc_ff;
      end
      isa_exec_pkg::ST_SLEEP: begin
        nxt_pc = pc_ff;
        nxt_state = wake_req ? isa_exec_pkg::ST_EXEC : isa_exec_pkg::ST_SLEEP;
      end
      default: begin
        nxt_pc = pc_ff;
      end
    endcase
  end

  // ==========================================================================
  // Core registers.
  // ==========================================================================
  // The no-operation word reaches only the pc update below.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pc_ff <= '0;
      state_ff <= isa_exec_pkg::ST_EXEC;
      status_ff <= isa_exec_pkg::STATUS_RST;
      acc_ff <= 8'h00;
      gie_ff <= 1'b0;
    end else begin
      pc_ff <= nxt_pc; // see RL22
      state_ff <= nxt_state;
      status_ff <= nxt_status;
      if (acc_we) begin
        acc_ff <= alu_res; // see RL6
      end
      if (exec && is_irq_exit) begin
        gie_ff <= 1'b1; // see RL11
      end
    end
  end

  // ==========================================================================
  // Return stack pointer.
  // ==========================================================================
  // The pointer wraps, so a ninth push overwrites the oldest entry.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sp_ff <= '0;
    end else if (push) begin
      sp_ff <= sp_ff + {{(SP_W-1){1'b0}}, 1'b1};
    end else if (pop) begin
      sp_ff <= sp_top;
    end
  end

  // ==========================================================================
  // Memories.
  // ==========================================================================
  // Data arrays carry no reset, which keeps them as plain RAM.
  always_ff @(posedge sys_clk) begin
    if (push) begin
      stk_mem[sp_ff] <= pc_inc; // see RL20
    end
    if (file_we) begin
      file_mem[faddr] <= file_wd; // see RL1
    end
  end

  // ==========================================================================
  // Special register write port.
  // ==========================================================================
  // One-cycle strobe with address and data held from flip-flops.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sreg_wr_en_ff <= 1'b0;
      sreg_addr_ff <= 6'h00;
      sreg_data_ff <= 8'h00;
    end else begin
      sreg_wr_en_ff <= exec && is_port_store; // see RL8
      if (exec && is_port_store) begin
        sreg_addr_ff <= instr_word[5:0];
        sreg_data_ff <= acc_ff;
      end
    end
  end

  assign pc = pc_ff;
  assign standby = (state_ff == isa_exec_pkg::ST_SLEEP);
  assign sreg_wr_en = sreg_wr_en_ff;
  assign sreg_addr = sreg_addr_ff;
  assign sreg_data = sreg_data_ff;

  // ==========================================================================
  // AXI4-Lite write channel.
  // ==========================================================================
  // Address and data are caught separately so either may come first.
  logic aw_held_ff;
  logic w_held_ff;
  logic [isa_exec_pkg::AXI_ADDR_W-1:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic w_strb0_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;

  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready = !w_held_ff && !bvalid_ff;
  wire do_write = aw_held_ff && w_held_ff && !bvalid_ff;
  wire wr_ctrl = (aw_addr_ff == isa_exec_pkg::REG_CTRL_OFS);
  wire wr_ro = (aw_addr_ff == isa_exec_pkg::REG_STATUS_OFS) || (aw_addr_ff == isa_exec_pkg::REG_ACC_OFS)
    || (aw_addr_ff == isa_exec_pkg::REG_PC_OFS);
  wire ctrl_hit = do_write && wr_ctrl && w_strb0_ff;
  assign wake_req = ctrl_hit && w_data_ff[isa_exec_pkg::CTRL_WAKE_BIT];

  // Holding flags and the response; read-only writes are dropped with OKAY.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff <= 32'h00000000;
      w_strb0_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= isa_exec_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb0_ff <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= (wr_ctrl || wr_ro) ? isa_exec_pkg::RESP_OKAY : isa_exec_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Run enable is the one software setting that steers the core.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      run_ff <= isa_exec_pkg::CTRL_RUN_RST;
    end else if (ctrl_hit) begin
      run_ff <= w_data_ff[isa_exec_pkg::CTRL_RUN_BIT];
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // ==========================================================================
  // AXI4-Lite read channel.
  // ==========================================================================
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rd_mux;
  logic rd_hit;

  assign s_axi_arready = !rvalid_ff;

  // Narrow registers sit in the low bits and the rest reads as zero.
  always_comb begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      isa_exec_pkg::REG_CTRL_OFS: rd_mux = {31'h00000000, run_ff};
      isa_exec_pkg::REG_STATUS_OFS: rd_mux = {25'h0000000, gie_ff, standby, status_ff};
      isa_exec_pkg::REG_ACC_OFS: rd_mux = {24'h000000, acc_ff};
      isa_exec_pkg::REG_PC_OFS: rd_mux = {{(32-PC_W){1'b0}}, pc_ff};
      default: rd_hit = 1'b0;
    endcase
  end

  // Data is captured at the address handshake and held until taken.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= isa_exec_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_mux;
      rresp_ff <= rd_hit ? isa_exec_pkg::RESP_OKAY : isa_exec_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

endmodule

/* core/isa_exec_pkg.sv */
// Shared constants and types for the instruction decode and execute block.
// Assumes a 14-bit instruction word, an 8-bit data path and a 32-bit AXI4-Lite bus.
//
// Function
// (RL1) increment_file adds one, updates zero only.
// (RL2) increment_skip_zero increments, skips next on zero.
// (RL3) or_literal_acc ORs literal into accumulator, zero.
// (RL4) or_acc_file ORs accumulator and file per d.
// (RL5) load_acc_from_file copies file to accumulator, no flags.
// (RL6) load_acc_literal loads literal, no flags.
// (RL7) store_acc_to_file writes accumulator to file.
// (RL8) store_acc_to_port_reg writes accumulator to special register.
// (RL9) File address is seven bits, d is one.
// (RL10) subroutine_exit pops stack into PC, two cycles.
// (RL11) interrupt_exit pops stack and sets interrupt enable.
// (RL12) table_exit_literal loads literal and returns, two cycles.
// (RL13) rotate_left_carry rotates through carry, carry only.
// (RL14) standby_entry enters standby, updates expiry and power-down.
// (RL15) subtract_acc_from_file subtracts, updates carry, half-carry, zero.
// (RL16) nibble_exchange swaps nibbles, no flags.
// (RL17) zero_test sets zero from file content only.
// (RL18) xor_literal_acc XORs literal into accumulator, zero.
// (RL19) xor_acc_file XORs accumulator and file per d.
// (RL20) Call pushes the following address onto stack.
// (RL21) Zero flag set on zero result, else cleared.
// (RL22) no_operation only advances the program counter.

package isa_exec_pkg;

  // ==========================================================================
  // Instruction encodings.
  // ==========================================================================
  localparam logic [13:0] NOP_WORD = 14'h0000;
  localparam logic [13:0] STANDBY_WORD = 14'h0003;
  localparam logic [13:0] WDT_CLEAR_WORD = 14'h0004;
  localparam logic [13:0] SUB_EXIT_WORD = 14'h0040;
  localparam logic [13:0] IRQ_EXIT_WORD = 14'h0060;
  localparam logic [7:0] PORT_STORE_PFX = 8'h00;
  localparam logic [6:0] FILE_STORE_PFX = 7'h01;
  localparam logic [1:0] CALL_PFX = 2'h2;
  localparam logic [1:0] JUMP_PFX = 2'h3;
  localparam logic [5:0] OP_SUB = 6'h02;
  localparam logic [5:0] OP_OR_F = 6'h04;
  localparam logic [5:0] OP_XOR_F = 6'h06;
  localparam logic [5:0] OP_LOAD_ZT = 6'h08;
  localparam logic [5:0] OP_INC = 6'h0A;
  localparam logic [5:0] OP_RLF = 6'h0D;
  localparam logic [5:0] OP_SWAP = 6'h0E;
  localparam logic [5:0] OP_INCSZ = 6'h0F;
  localparam logic [5:0] OP_TABLE_EXIT = 6'h18;
  localparam logic [5:0] OP_LOAD_LIT = 6'h19;
  localparam logic [5:0] OP_OR_LIT = 6'h1A;
  localparam logic [5:0] OP_XOR_LIT = 6'h1F;

  // ==========================================================================
  // Core sizes and register map.
  // ==========================================================================
  localparam int PC_WIDTH = 12;
  localparam int STACK_DEPTH = 8;
  localparam int FILE_DEPTH = 128;
  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] REG_CTRL_OFS = 8'h00;
  localparam logic [7:0] REG_STATUS_OFS = 8'h04;
  localparam logic [7:0] REG_ACC_OFS = 8'h08;
  localparam logic [7:0] REG_PC_OFS = 8'h0C;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_WAKE_BIT = 1;
  localparam logic CTRL_RUN_RST = 1'b0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Types.
  // ==========================================================================
  // Status flags, most significant first, as they read in the status register.
  typedef struct packed {
    logic wd_expiry;
    logic power_down;
    logic zero;
    logic half_carry;
    logic carry;
  } status_s;

  localparam status_s STATUS_RST = 5'h18;

  typedef enum logic [2:0] {
    ALU_PASS = 3'h0,
    ALU_INC = 3'h1,
    ALU_OR = 3'h2,
    ALU_XOR = 3'h3,
    ALU_SUB = 3'h4,
    ALU_RLF = 3'h5,
    ALU_SWAP = 3'h6
  } alu_op_e;

  typedef enum logic [3:0] {
    ST_EXEC = 4'h1,
    ST_SKIP = 4'h2,
    ST_WAIT = 4'h4,
    ST_SLEEP = 4'h8
  } core_state_e;

endpackage

/* core/byte_alu.sv */
// Combinational byte arithmetic unit of the execute stage.
// Assumes operands are stable for the whole cycle; the caller registers results.

`timescale 1ns/1ps

module byte_alu (
  input wire isa_exec_pkg::alu_op_e op,
  input wire logic [7:0] acc,
  input wire logic [7:0] opnd,
  input wire logic carry_in,
  output logic [7:0] result,
  output logic carry_out,
  output logic half_carry_out,
  output logic zero_out
);

  // ==========================================================================
  // Subtraction as opnd plus inverted acc plus one.
  // ==========================================================================
  // Carry out of the true sum means no borrow, which is the carry sense wanted.
  wire [8:0] sub_full = {1'b0, opnd} + {1'b0, ~acc} + 9'h001;
  wire [4:0] sub_low = {1'b0, opnd[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;

  // ==========================================================================
  // Result selection.
  // ==========================================================================
  // Flags not touched by an operation are simply ignored by the caller.
  always_comb begin
    result = opnd;
    carry_out = carry_in;
    half_carry_out = 1'b0;
    case (op)
      isa_exec_pkg::ALU_INC: begin
        result = opnd + 8'h01; // see RL1
      end
      isa_exec_pkg::ALU_OR: begin
        result = acc | opnd; // see RL4
      end
      isa_exec_pkg::ALU_XOR: begin
        result = acc ^ opnd; // see RL19
      end
      isa_exec_pkg::ALU_SUB: begin
        result = sub_full[7:0]; // see RL15
        carry_out = sub_full[8];
        half_carry_out = sub_low[4];
      end
      isa_exec_pkg::ALU_RLF: begin
        result = {opnd[6:0], carry_in}; // see RL13
        carry_out = opnd[7];
      end
      isa_exec_pkg::ALU_SWAP: begin
        result = {opnd[3:0], opnd[7:4]}; // see RL16
      end
      default: begin
        result = opnd;
      end
    endcase
  end

  // Zero reflects the whole eight-bit result, set or cleared.
  assign zero_out = (result == 8'h00); // see RL21

endmodule

/* test/isa_exec_props.sv */
// Port checker for the execute block: pc flow, port stores and standby.
// Assumes instr_word shows the word at pc in the same cycle.
`timescale 1ns/1ps
module isa_exec_props #(
  parameter int PC_W = 12
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [13:0] instr_word,
  input wire logic [PC_W-1:0] pc,
  input wire logic standby,
  input wire logic sreg_wr_en,
  input wire logic [5:0] sreg_addr
);
  // ==========
  // Helpers. The word after an increment-and-skip may be discarded, so it is not judged.
  logic sz_ff;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) sz_ff <= 1'b0;
    else sz_ff <= instr_word[13:8] == isa_exec_pkg::OP_INCSZ;
  end
  wire live = !sz_ff && !standby;
  wire port_wd = instr_word[13:6] == 8'h00 && !(instr_word[5:0] inside {6'h00, 6'h03, 6'h04});
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // A taken exit moves pc, then idles for one cycle.
  property p_exit(logic hit);
    live && hit ##1 pc != $past(pc) |-> ##1 $stable(pc);
  endproperty
  // ==========
  // Assertions.
  a_nop_step: assert property (
    live && instr_word == 14'h0000 |=> (pc == $past(pc) + 1'b1 || $stable(pc))) else $error("nop pc step");
  a_store_pulse: assert property (
    live && port_wd ##1 pc == $past(pc) + 1'b1 |-> sreg_wr_en && sreg_addr == $past(instr_word[5:0]))
    else $error("port store lost");
  a_store_cause: assert property (
    sreg_wr_en |-> $past(instr_word[13:6]) == 8'h00) else $error("stray port store");
  a_sleep_cause: assert property (
    $rose(standby) |-> $past(instr_word) == isa_exec_pkg::STANDBY_WORD) else $error("stray standby");
  a_sleep_hold: assert property (
    standby ##1 standby |-> $stable(pc)) else $error("pc moved in standby");
  a_sub_exit: assert property (
    p_exit(instr_word == isa_exec_pkg::SUB_EXIT_WORD)) else $error("exit length");
  a_irq_exit: assert property (
    p_exit(instr_word == isa_exec_pkg::IRQ_EXIT_WORD)) else $error("exit length");
  a_table_exit: assert property (
    p_exit(instr_word[13:8] == isa_exec_pkg::OP_TABLE_EXIT)) else $error("exit length");
  c_store: cover property (sreg_wr_en);
  c_sleep: cover property ($rose(standby));
  c_wake: cover property ($fell(standby));
endmodule
bind isa_exec_inc_to_xor isa_exec_props #(.PC_W(PC_W)) u_isa_exec_props (.sys_clk(sys_clk), .rstn(rstn),
  .instr_word(instr_word), .pc(pc), .standby(standby), .sreg_wr_en(sreg_wr_en), .sreg_addr(sreg_addr));

/* test/testbench.sv */
// Bench: runs a program table on the core and reads results over AXI4-Lite.
// Assumes the table feeds instr_word from pc with no delay.
`timescale 1ns/1ps
module testbench;
  logic sys_clk, rstn, standby, sreg_wr_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] pc;
  logic [5:0] sreg_addr;
  logic [7:0] sreg_data, s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [13:0] instr_word, rom [0:63];
  logic [33:0] bus_q[$], port_q[$];
  int bad_count = 0, comparisons = 0, cycles = 0;
  assign instr_word = rom[pc[5:0]];
  isa_exec_inc_to_xor u_isa_exec_inc_to_xor (.sys_clk, .rstn, .instr_word, .pc, .standby, .sreg_wr_en,
    .sreg_addr, .sreg_data, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task complete_run();
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Results are looked at mid-cycle, where every edge's updates have landed.
  always @(negedge sys_clk) begin
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, bus_q.pop_front());
    if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0}, bus_q.pop_front());
    if (sreg_wr_en) chk({20'h0, sreg_addr, sreg_data}, port_q.pop_front());
  end
  // Ceiling far above the expected run, so a hang ends in the report.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      complete_run();
    end
  end
  // One AXI4-Lite transfer; each channel is released only after its handshake.
  task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] dat, input logic [33:0] exp);
    logic ta, tw, tr, fin;
    bus_q.push_back(exp);
    fin = 1'b0;
    @(posedge sys_clk);
    if (wr) begin
      s_axi_awaddr <= adr;
      s_axi_wdata <= dat;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= adr;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    while (!fin) begin
      @(negedge sys_clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tr = s_axi_arvalid && s_axi_arready;
      fin = wr ? s_axi_bvalid : s_axi_rvalid;
      @(posedge sys_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tr) s_axi_arvalid <= 1'b0;
      if (fin) {s_axi_bready, s_axi_rready} <= 2'b00;
    end
  endtask
  task automatic wait_sleep(input logic [11:0] at);
    for (int i = 0; i < 300 && !(standby && pc == at); i++) @(negedge sys_clk);
  endtask
  initial begin
    logic [7:0] a;
    logic [7:0] b;
    int i;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    rstn = 1'b0;
    i = $urandom(97008);
    a = 8'($urandom_range(254, 0));
    b = a + 8'h01;
    rom = '{0: {6'h19, a}, 1: 14'h0085, 2: 14'h003F, 3: {6'h1F, a}, 4: 14'h0F85, 5: 14'h0805, 6: 14'h0205,
      7: 14'h0E05, 8: 14'h0021, 9: 14'h0885, 10: 14'h19FF, 11: 14'h0086, 12: 14'h0F86, 13: 14'h1955,
      14: 14'h0022, 15: 14'h0D06, 16: 14'h2020, 17: 14'h2021, 18: 14'h2022, 19: 14'h1A80, 20: 14'h0A86,
      21: 14'h0606, 22: 14'h0486, 23: 14'h0023, 24: 14'h0806, 25: 14'h0024, 26: 14'h0003, 28: 14'h0003,
      32: 14'h1877, 33: 14'h0060, 34: 14'h0040, default: 14'h0000};
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    bus(1'b0, 8'h00, 32'h0, 34'h0);
    bus(1'b0, 8'h04, 32'h0, {2'h0, 32'h18});
    bus(1'b0, 8'h0C, 32'h0, 34'h0);
    $display("reset test done");
    port_q.push_back({20'h0, 6'h3F, a});
    port_q.push_back({20'h0, 6'h21, b[3:0], b[7:4]});
    port_q.push_back({20'h0, 6'h22, 8'hFF});
    port_q.push_back({20'h0, 6'h23, 8'hF6});
    port_q.push_back({20'h0, 6'h24, 8'hF7});
    bus(1'b1, 8'h00, 32'h1, 34'h0);
    wait_sleep(12'h01B);
    bus(1'b0, 8'h08, 32'h0, {2'h0, 32'hF7});
    bus(1'b1, 8'h04, 32'hFF, 34'h0);
    bus(1'b0, 8'h04, 32'h0, {2'h0, 32'h72});
    bus(1'b0, 8'h0C, 32'h0, {2'h0, 32'h1B});
    bus(1'b0, 8'h10, 32'h0, {2'h2, 32'h0});
    bus(1'b1, 8'h14, 32'h0, {2'h2, 32'h0});
    $display("program test done");
    bus(1'b1, 8'h00, 32'h3, 34'h0);
    wait_sleep(12'h01D);
    bus(1'b0, 8'h0C, 32'h0, {2'h0, 32'h1D});
    bus(1'b0, 8'h00, 32'h0, {2'h0, 32'h1});
    $display("wake test done");
    chk(34'(port_q.size()), 34'h0);
    complete_run();
  end
endmodule
